// ---- verilog/ubm_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ubm_params.svh"
module ubm_top #(
  parameter int unsigned QDEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire ubm_pkg::ubm_wb_req_type wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire ubm_pkg::ubm_cycle_type cyc_i,
  input wire ubm_pkg::ubm_exec_type exec_i,
  input wire ubm_pkg::ubm_branch_type br_i,
  output logic brk_req_o
);
  import ubm_pkg::*;

  // register storage
  logic [31:0] match_address_reg [2];
  logic [31:0] match_address_mask_reg [2];
  logic [15:0] cycle_condition_reg [2];
  logic [31:0] match_value_b_reg;
  logic [31:0] match_value_mask_b_reg;
  logic [1:0] after_exec_select_reg;
  logic [1:0] lbus_hit_flag_reg;
  logic [1:0] ibus_hit_flag_reg;
  logic chain_a_then_b_reg;
  logic count_en_reg;
  logic trace_enable_reg;
  logic [11:0] hit_count_down_reg;
  logic chain_armed_reg;
  logic [27:0] target_address_reg [QDEPTH];
  logic [27:0] origin_address_reg [QDEPTH];
  logic target_valid_reg [QDEPTH];
  logic origin_valid_reg [QDEPTH];
  ubm_brk_state_type brk_state_reg;
  ubm_brk_state_type brk_state_next;

  // bus decode
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] bus_wdat;
  logic [31:0] rdata;
  logic trace_restart;
  logic trace_pop;
  logic trace_push;

  // match results
  logic [1:0] pair_ok;
  logic [1:0] fetch_hit;
  logic [1:0] data_hit;
  logic [1:0] hit;
  logic value_ok;
  logic fire_a;
  logic fire_b;
  logic fire_now;
  logic fire_late;

  // byte-lane merge of write data into an old value
  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_lanes

  // one request is taken per cycle; ack follows one cycle later
  assign bus_req = wb_i.cyc & wb_i.stb & ~wb_ack_o;
  assign bus_wr = bus_req & wb_i.we;
  assign bus_rd = bus_req & ~wb_i.we;
  assign bus_wdat = wb_i.dat;

  // trace side effects of register access, and the push at a branch
  assign trace_restart = bus_wr & (wb_i.adr == `UBM_OFF_CTRL) & wb_i.sel[1]
    & bus_wdat[`UBM_CR_TRACE_EN]; // [RULE2] [RULE26]
  assign trace_pop = bus_rd & (wb_i.adr == `UBM_OFF_TARGET); // [RULE4]
  assign trace_push = br_i.vld & trace_enable_reg; // [RULE26]

  // read data selection
  always_comb begin
    rdata = `UBM_RST_WORD;
    if (wb_i.adr == `UBM_OFF_ADDR_A) begin
      rdata = match_address_reg[0];
    end else if (wb_i.adr == `UBM_OFF_MASK_A) begin
      rdata = match_address_mask_reg[0];
    end else if (wb_i.adr == `UBM_OFF_COND_A) begin
      rdata = {16'h0000, cycle_condition_reg[0]};
    end else if (wb_i.adr == `UBM_OFF_ADDR_B) begin
      rdata = match_address_reg[1];
    end else if (wb_i.adr == `UBM_OFF_MASK_B) begin
      rdata = match_address_mask_reg[1];
    end else if (wb_i.adr == `UBM_OFF_VAL_B) begin
      rdata = match_value_b_reg;
    end else if (wb_i.adr == `UBM_OFF_VMASK_B) begin
      rdata = match_value_mask_b_reg;
    end else if (wb_i.adr == `UBM_OFF_COND_B) begin
      rdata = {16'h0000, cycle_condition_reg[1]};
    end else if (wb_i.adr == `UBM_OFF_CTRL) begin
      rdata[`UBM_CR_COUNT_EN] = count_en_reg;
      rdata[`UBM_CR_CHAIN] = chain_a_then_b_reg;
      rdata[`UBM_CR_AFTER_B] = after_exec_select_reg[1];
      rdata[`UBM_CR_TRACE_EN] = trace_enable_reg;
      rdata[`UBM_CR_AFTER_A] = after_exec_select_reg[0];
      rdata[`UBM_CR_IBUS_B] = ibus_hit_flag_reg[1];
      rdata[`UBM_CR_IBUS_A] = ibus_hit_flag_reg[0];
      rdata[`UBM_CR_LBUS_B] = lbus_hit_flag_reg[1];
      rdata[`UBM_CR_LBUS_A] = lbus_hit_flag_reg[0];
    end else if (wb_i.adr == `UBM_OFF_COUNT) begin
      rdata = {20'h00000, hit_count_down_reg};
    end else if (wb_i.adr == `UBM_OFF_ORIGIN) begin
      rdata = {origin_valid_reg[0], 3'h0, origin_address_reg[0]};
    end else if (wb_i.adr == `UBM_OFF_TARGET) begin
      rdata = {target_valid_reg[0], 3'h0, target_address_reg[0]}; // [RULE1]
    end
  end

  // bus answer; unmapped offsets read zero and ignore writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `UBM_RST_WORD;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // address, mask and condition registers of both channels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_address_reg[0] <= `UBM_RST_WORD;
      match_address_reg[1] <= `UBM_RST_WORD;
      match_address_mask_reg[0] <= `UBM_RST_WORD;
      match_address_mask_reg[1] <= `UBM_RST_WORD;
      cycle_condition_reg[0] <= `UBM_RST_COND;
      cycle_condition_reg[1] <= `UBM_RST_COND;
      match_value_b_reg <= `UBM_RST_WORD;
      match_value_mask_b_reg <= `UBM_RST_WORD;
    end else if (ce_i & bus_wr) begin
      if (wb_i.adr == `UBM_OFF_ADDR_A) begin
        match_address_reg[0] <= merge_lanes(match_address_reg[0], bus_wdat, wb_i.sel);
      end else if (wb_i.adr == `UBM_OFF_MASK_A) begin
        match_address_mask_reg[0] <= merge_lanes(match_address_mask_reg[0], bus_wdat,
          wb_i.sel);
      end else if (wb_i.adr == `UBM_OFF_COND_A) begin
        // condition word taken whole from the low half, as for channel B
        cycle_condition_reg[0] <= bus_wdat[15:0];
      end else if (wb_i.adr == `UBM_OFF_ADDR_B) begin
        match_address_reg[1] <= merge_lanes(match_address_reg[1], bus_wdat, wb_i.sel);
      end else if (wb_i.adr == `UBM_OFF_MASK_B) begin
        match_address_mask_reg[1] <= merge_lanes(match_address_mask_reg[1], bus_wdat,
          wb_i.sel);
      end else if (wb_i.adr == `UBM_OFF_VAL_B) begin
        match_value_b_reg <= merge_lanes(match_value_b_reg, bus_wdat, wb_i.sel);
      end else if (wb_i.adr == `UBM_OFF_VMASK_B) begin
        match_value_mask_b_reg <= merge_lanes(match_value_mask_b_reg, bus_wdat, wb_i.sel);
      end else if (wb_i.adr == `UBM_OFF_COND_B) begin
        cycle_condition_reg[1] <= bus_wdat[15:0];
      end
    end
  end

  // control bits and the execution counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      after_exec_select_reg <= 2'h0;
      chain_a_then_b_reg <= 1'b0;
      count_en_reg <= 1'b0;
      trace_enable_reg <= 1'b0;
      hit_count_down_reg <= `UBM_RST_COUNT;
    end else if (ce_i) begin
      if (bus_wr & (wb_i.adr == `UBM_OFF_CTRL)) begin
        after_exec_select_reg <= {bus_wdat[`UBM_CR_AFTER_B],
          bus_wdat[`UBM_CR_AFTER_A]}; // [RULE10]
        chain_a_then_b_reg <= bus_wdat[`UBM_CR_CHAIN];
        count_en_reg <= bus_wdat[`UBM_CR_COUNT_EN];
        trace_enable_reg <= bus_wdat[`UBM_CR_TRACE_EN];
      end
      if (bus_wr & (wb_i.adr == `UBM_OFF_COUNT)) begin
        hit_count_down_reg <= bus_wdat[11:0];
      end else if (count_en_reg & hit[1] & (hit_count_down_reg > `UBM_COUNT_LAST)) begin
        hit_count_down_reg <= hit_count_down_reg - `UBM_COUNT_LAST; // [RULE24]
      end
    end
  end

  // per-channel condition matching
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [15:0] cc;
    logic [31:0] ign;
    logic bus_ok;
    logic rw_ok;
    logic sz_ok;
    assign cc = cycle_condition_reg[c];
    assign pair_ok[c] = (|cc[1:0]) & (|cc[3:2]) & (|cc[5:4]); // [RULE7]
    // fetch: compare whole address, low bit must be clear
    assign fetch_hit[c] = exec_i.vld & pair_ok[c] & cc[`UBM_CC_BUS_L]
      & cc[`UBM_CC_FETCH] & cc[`UBM_CC_RD] & ~match_address_reg[c][0] // [RULE11]
      & (((exec_i.addr ^ match_address_reg[c])
      & ~match_address_mask_reg[c]) == 32'h0000_0000); // [RULE25]
    // data: low address bits dropped by access size
    assign ign = (cyc_i.size == SZ_LONG) ? 32'h0000_0003 :
      (cyc_i.size == SZ_WORD) ? 32'h0000_0001 : 32'h0000_0000; // [RULE16]
    assign bus_ok = cyc_i.ibus ? cc[`UBM_CC_BUS_I] : cc[`UBM_CC_BUS_L];
    assign rw_ok = cyc_i.wr ? cc[`UBM_CC_WR] : cc[`UBM_CC_RD];
    assign sz_ok = (cc[`UBM_CC_SZ +: 2] == SZ_NONE)
      | (cc[`UBM_CC_SZ +: 2] == cyc_i.size);
    assign data_hit[c] = cyc_i.vld & ~cyc_i.fetch & cyc_i.from_insn // [RULE17]
      & pair_ok[c] & bus_ok & rw_ok & sz_ok & cc[`UBM_CC_DATA]
      & (((cyc_i.addr ^ match_address_reg[c])
      & ~match_address_mask_reg[c] & ~ign) == 32'h0000_0000); // [RULE16] [RULE25]
  end

  // channel B value compare, only for data cycles with a size set
  always_comb begin
    logic [31:0] vm;
    vm = (cycle_condition_reg[1][`UBM_CC_SZ +: 2] == SZ_LONG) ? 32'hffff_ffff :
      32'h0000_ffff; // [RULE20]
    value_ok = (cycle_condition_reg[1][`UBM_CC_SZ +: 2] == SZ_NONE)
      | (((cyc_i.data ^ match_value_b_reg) & ~match_value_mask_b_reg & vm)
      == 32'h0000_0000); // [RULE18]
  end

  assign hit[0] = fetch_hit[0] | data_hit[0];
  assign hit[1] = fetch_hit[1] | (data_hit[1] & value_ok); // [RULE15] [RULE18]

  // channel firing with count and chain qualification
  assign fire_a = hit[0] & ~chain_a_then_b_reg;
  assign fire_b = hit[1] & (~count_en_reg | (hit_count_down_reg == `UBM_COUNT_LAST))
    & (~chain_a_then_b_reg | chain_armed_reg); // [RULE21] [RULE23] [RULE24]

  // fire now only for a before-exec fetch at an accepting boundary
  assign fire_now = exec_i.accept & ((fire_a & fetch_hit[0] & ~after_exec_select_reg[0])
    | (fire_b & fetch_hit[1] & ~after_exec_select_reg[1])); // [RULE12]
  assign fire_late = (fire_a | fire_b) & ~fire_now; // [RULE13]

  // chain memory of an earlier channel A match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain_armed_reg <= 1'b0;
    end else if (ce_i) begin
      if (~chain_a_then_b_reg) begin
        chain_armed_reg <= 1'b0; // [RULE22]
      end else if (fire_b) begin
        chain_armed_reg <= 1'b0;
      end else if (hit[0]) begin
        chain_armed_reg <= 1'b1; // [RULE21]
      end
    end
  end

  // sticky hit flags; a hit beats a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lbus_hit_flag_reg <= 2'h0;
      ibus_hit_flag_reg <= 2'h0;
    end else if (ce_i) begin
      for (int c = 0; c < 2; c++) begin
        if (bus_wr & (wb_i.adr == `UBM_OFF_CTRL) & wb_i.sel[1]) begin
          if (~bus_wdat[`UBM_CR_LBUS_A - c]) begin
            lbus_hit_flag_reg[c] <= 1'b0; // [RULE6]
          end
          if (~bus_wdat[`UBM_CR_IBUS_A - c]) begin
            ibus_hit_flag_reg[c] <= 1'b0; // [RULE6]
          end
        end
        if ((c == 0) ? fire_a : fire_b) begin
          lbus_hit_flag_reg[c] <= 1'b1; // [RULE5]
          ibus_hit_flag_reg[c] <= 1'b1; // [RULE5]
        end
      end
    end
  end

  // break request sequencer, one request per merged event
  always_comb begin
    brk_state_next = brk_state_reg;
    case (brk_state_reg)
      BRK_IDLE: begin
        if (fire_now) begin
          brk_state_next = BRK_REQ;
        end else if (fire_late) begin
          brk_state_next = BRK_WAIT; // [RULE13]
        end
      end
      BRK_WAIT: begin
        if (exec_i.vld & exec_i.accept) begin
          brk_state_next = BRK_REQ; // [RULE12] [RULE13]
        end
      end
      BRK_REQ: begin
        brk_state_next = BRK_IDLE; // [RULE9]
      end
      default: begin
        brk_state_next = BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_state_reg <= BRK_IDLE;
      brk_req_o <= 1'b0;
    end else if (ce_i) begin
      brk_state_reg <= brk_state_next;
      brk_req_o <= (brk_state_next == BRK_REQ); // [RULE5] [RULE9]
    end
  end

  // trace queues: push at a branch, else pop after a target read
  for (genvar i = 0; i < QDEPTH; i++) begin : g_q
    always_ff @(posedge clk_i) begin
      if (ce_i & trace_push) begin
        target_address_reg[i] <= (i == 0) ? br_i.dst[27:0] :
          target_address_reg[(i == 0) ? 0 : i - 1]; // [RULE1] [RULE3]
        origin_address_reg[i] <= (i == 0) ? br_i.src[27:0] :
          origin_address_reg[(i == 0) ? 0 : i - 1];
      end else if (ce_i & trace_pop & (i < QDEPTH - 1)) begin
        target_address_reg[i] <= target_address_reg[(i < QDEPTH - 1) ? i + 1 : i];
        origin_address_reg[i] <= origin_address_reg[(i < QDEPTH - 1) ? i + 1 : i];
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        target_valid_reg[i] <= 1'b0; // [RULE2]
        origin_valid_reg[i] <= 1'b0;
      end else if (ce_i) begin
        if (trace_restart) begin
          target_valid_reg[i] <= 1'b0; // [RULE2] [RULE26]
          origin_valid_reg[i] <= 1'b0;
        end else if (trace_push) begin
          target_valid_reg[i] <= (i == 0) ? 1'b1 :
            target_valid_reg[(i == 0) ? 0 : i - 1]; // [RULE3]
          origin_valid_reg[i] <= (i == 0) ? 1'b1 :
            origin_valid_reg[(i == 0) ? 0 : i - 1];
        end else if (trace_pop) begin
          target_valid_reg[i] <= (i < QDEPTH - 1) ?
            target_valid_reg[(i < QDEPTH - 1) ? i + 1 : i] : 1'b0; // [RULE2] [RULE4]
          origin_valid_reg[i] <= (i < QDEPTH - 1) ?
            origin_valid_reg[(i < QDEPTH - 1) ? i + 1 : i] : 1'b0; // [RULE4]
        end
      end
    end
  end
endmodule : ubm_top
`default_nettype wire

// ---- verilog/ubm_params.svh ----
`ifndef UBM_PARAMS_SVH
`define UBM_PARAMS_SVH
// What this block does
// RULE1: branch target bits 27..0 stored, valid in bit 31, bits 30..28 read zero.
// RULE2: target valid clears on read, trace enable write, reset; address not reset.
// RULE3: target entries form a four-deep queue shifted at every branch.
// RULE4: origin and target queues share one pointer; advance after target read.
// RULE5: satisfied channel issues one break request and sets its hit flags.
// RULE6: hit flags stay set until software writes zero to them.
// RULE7: any condition field pair at 00 disables that channel's break.
// RULE8: software programs all settings before the cycle condition registers.
// RULE9: coinciding data and fetch breaks give only one break request.
// RULE10: per-channel bit picks break before or after fetched instruction executes.
// RULE11: fetch condition never breaks while break address bit 0 is one.
// RULE12: before-exec break waits for confirmed execution, delay slot waits for acceptance.
// RULE13: after-exec break fires before next instruction, waiting for acceptance.
// RULE14: software avoids before-exec on delay slots and after-exec on sleep.
// RULE15: channel B fetch condition ignores the match value.
// RULE16: data address compare uses bits 31..2, 31..1 or 31..0 by size.
// RULE17: data matches only count cycles coming from instruction execution.
// RULE18: channel B with size set needs address and masked value both matching.
// RULE19: software repeats a byte value in both low bytes of value and mask.
// RULE20: word or byte size ignores bits 31..16 of value and mask.
// RULE21: chain mode breaks on B only after an earlier A match.
// RULE22: clearing chain mode drops a waiting A match.
// RULE23: chain mode keeps bus selection and count; fires at count 0001.
// RULE24: count enabled decrements per B match, breaks on match at 0001.
// RULE25: address bits with mask bit one are not compared.
// RULE26: trace captures only while enabled; re-enable invalidates queue.
`define UBM_OFF_ADDR_A 8'h00
`define UBM_OFF_MASK_A 8'h04
`define UBM_OFF_COND_A 8'h08
`define UBM_OFF_ADDR_B 8'h0c
`define UBM_OFF_MASK_B 8'h10
`define UBM_OFF_VAL_B 8'h14
`define UBM_OFF_VMASK_B 8'h18
`define UBM_OFF_COND_B 8'h1c
`define UBM_OFF_CTRL 8'h20
`define UBM_OFF_COUNT 8'h24
`define UBM_OFF_ORIGIN 8'h28
`define UBM_OFF_TARGET 8'h2c
`define UBM_CC_BUS_L 0
`define UBM_CC_BUS_I 1
`define UBM_CC_FETCH 2
`define UBM_CC_DATA 3
`define UBM_CC_RD 4
`define UBM_CC_WR 5
`define UBM_CC_SZ 6
`define UBM_CR_COUNT_EN 0
`define UBM_CR_CHAIN 3
`define UBM_CR_AFTER_B 6
`define UBM_CR_TRACE_EN 8
`define UBM_CR_AFTER_A 10
`define UBM_CR_IBUS_B 12
`define UBM_CR_IBUS_A 13
`define UBM_CR_LBUS_B 14
`define UBM_CR_LBUS_A 15
`define UBM_TR_VALID 31
`define UBM_RST_WORD 32'h0000_0000
`define UBM_RST_COND 16'h0000
`define UBM_RST_COUNT 12'h000
`define UBM_COUNT_LAST 12'h001
`endif

// ---- verilog/ubm_pkg.sv ----
package ubm_pkg;
  typedef enum logic [1:0] {SZ_NONE = 2'h0, SZ_BYTE = 2'h1, SZ_WORD = 2'h2,
    SZ_LONG = 2'h3} ubm_size_type;
  typedef enum logic [1:0] {BRK_IDLE = 2'h0, BRK_WAIT = 2'h1,
    BRK_REQ = 2'h3} ubm_brk_state_type;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } ubm_wb_req_type;
  typedef struct packed {
    logic vld;
    logic ibus;
    logic fetch;
    logic wr;
    logic from_insn;
    ubm_size_type size;
    logic [31:0] addr;
    logic [31:0] data;
  } ubm_cycle_type;
  typedef struct packed {
    logic vld;
    logic accept;
    logic [31:0] addr;
  } ubm_exec_type;
  typedef struct packed {
    logic vld;
    logic [31:0] src;
    logic [31:0] dst;
  } ubm_branch_type;
endpackage : ubm_pkg

// ---- test/ubm_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module ubm_top_sva
  import ubm_pkg::*;
#(
  parameter int unsigned QDEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire ubm_pkg::ubm_wb_req_type wb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire ubm_pkg::ubm_cycle_type cyc_i,
  input wire ubm_pkg::ubm_exec_type exec_i,
  input wire ubm_pkg::ubm_branch_type br_i,
  input wire logic brk_req_o
);
  // read that completes in this cycle
  logic rd_ack;
  assign rd_ack = wb_ack_o && !wb_i.we;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus answer one cycle after the taking edge, then ack drops
  AST_ACK_ANSWER: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("ack did not follow request");
  AST_ACK_ONE: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // break request is a single pulse at an accepting boundary
  AST_BRK_ONE: assert property (brk_req_o && ce_i |=> !brk_req_o)
    else $error("break request not a single pulse");
  AST_BRK_AT: assert property ($rose(brk_req_o) |-> $past(exec_i.vld && exec_i.accept))
    else $error("break not at accepting instruction");
  // reserved and unmapped read data, read data held between reads
  AST_TRACE_RSVD: assert property (rd_ack && wb_i.adr inside {8'h28, 8'h2c}
    |-> wb_dat_o[30:28] == 3'h0)
    else $error("trace reserved bits not zero");
  AST_CTRL_RSVD: assert property (rd_ack && wb_i.adr == 8'h20 |-> wb_dat_o[2:1] == 2'h0)
    else $error("control reserved bits not zero");
  AST_COUNT_RSVD: assert property (rd_ack && wb_i.adr == 8'h24 |-> wb_dat_o[31:12] == 20'h0)
    else $error("count upper bits not zero");
  AST_UNMAPPED: assert property (rd_ack && wb_i.adr >= 8'h30 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> rd_ack)
    else $error("read data changed outside a read");
endmodule : ubm_top_sva
bind ubm_top ubm_top_sva #(.QDEPTH(QDEPTH)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cyc_i(cyc_i),
  .exec_i(exec_i), .br_i(br_i), .brk_req_o(brk_req_o));
`default_nettype wire

// ---- test/ubm_core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ubm_core_model (
  input wire logic clk_i,
  output var ubm_pkg::ubm_cycle_type cyc_o,
  output var ubm_pkg::ubm_exec_type exec_o,
  output var ubm_pkg::ubm_branch_type br_o
);
  import ubm_pkg::*;
  // idle buses at time zero
  initial begin
    cyc_o = '0;
    exec_o = '0;
    br_o = '0;
  end
  // confirmed instruction, break-accepting unless told otherwise; released lines show inverse
  task automatic exec_at(input logic [31:0] a, input logic acc = 1'b1);
    @(posedge clk_i);
    exec_o <= '{vld: 1'b1, accept: acc, addr: a};
    @(posedge clk_i);
    exec_o <= '{vld: 1'b0, accept: ~acc, addr: ~a};
  endtask : exec_at
  // one data cycle, L bus read unless told otherwise
  task automatic data_at(input logic [31:0] a, input ubm_size_type s, input logic f,
    input logic [31:0] d, input logic ib = 1'b0, input logic w = 1'b0);
    @(posedge clk_i);
    cyc_o <= '{vld: 1'b1, ibus: ib, fetch: 1'b0, wr: w, from_insn: f, size: s,
      addr: a, data: d};
    @(posedge clk_i);
    cyc_o <= '{vld: 1'b0, ibus: ~ib, fetch: 1'b1, wr: ~w, from_insn: ~f, size: s,
      addr: ~a, data: ~d};
  endtask : data_at
  // one taken branch
  task automatic branch(input logic [31:0] s, input logic [31:0] d);
    @(posedge clk_i);
    br_o <= '{vld: 1'b1, src: s, dst: d};
    @(posedge clk_i);
    br_o <= '{vld: 1'b0, src: ~s, dst: ~d};
  endtask : branch
endmodule : ubm_core_model
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ubm_pkg::*;
  logic clk_i;
  logic rst_i;
  logic ce;
  ubm_wb_req_type wb;
  logic wb_ack;
  logic [31:0] wb_dat;
  ubm_cycle_type cyc;
  ubm_exec_type ex;
  ubm_branch_type br;
  logic brk;
  logic [31:0] q;
  int error_cnt = 0;
  int n_compared = 0;
  int brk_cnt = 0;
  int b0 = 0;
  // data access rows: size, address, origin, data, value, hit
  logic [1:0] d_sz [7] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2};
  logic [31:0] d_ad [7] = '{32'h1000, 32'h1002, 32'h1003, 32'h1002, 32'h1000, 32'h1000,
    32'h1002};
  logic d_fr [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [31:0] d_dt [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h55, 32'h0};
  logic [31:0] d_vb [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hffff_0000};
  logic [31:0] d_ex [7] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h1};
  logic [31:0] off_cond [3] = '{32'h14, 32'h11, 32'h05};
  ubm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb), .wb_ack_o(wb_ack),
    .wb_dat_o(wb_dat), .cyc_i(cyc), .exec_i(ex), .br_i(br), .brk_req_o(brk));
  ubm_core_model CORE (.clk_i(clk_i), .cyc_o(cyc), .exec_o(ex), .br_o(br));
  // clock and break pulse counter
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (brk === 1'b1) brk_cnt <= brk_cnt + 1;
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask : chk
  // classic single cycle, held until ack is sampled; only the watchdog ends a wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    wb <= '0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    xfer(1'b1, a, d, s);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, a, 32'h0, 4'hf);
    chk(q, e, m);
  endtask : rd
  // address, mask, then cycle condition last
  task automatic chan(input logic [7:0] b, input logic [31:0] a, input logic [31:0] m,
    input logic [31:0] c);
    wr(b, a);
    wr(b + 8'h04, m);
    wr((b == 8'h00) ? 8'h08 : 8'h1c, c);
  endtask : chan
  task automatic hits(input logic [31:0] e);
    repeat (3) @(posedge clk_i);
    chk(32'(brk_cnt - b0), e, '1);
    b0 = brk_cnt;
  endtask : hits
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    stop_test();
  end
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    wb = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h20, 32'h0, '1);
    rd(8'h24, 32'h0, '1);
    rd(8'h2c, 32'h0, 32'h8000_0000);
    rd(8'h30, 32'h0, '1);
    wr(8'h00, 32'h1122_3344);
    wr(8'h00, 32'haabb_ccdd, 4'h5);
    rd(8'h00, 32'h11bb_33dd, '1);
    $display("test reset done");
    chan(8'h00, 32'h404, 32'h0, 32'h15);
    CORE.exec_at(32'h404);
    hits(1);
    rd(8'h20, 32'ha000, '1);
    wr(8'h20, 32'h0);
    rd(8'h20, 32'h0, '1);
    CORE.exec_at(32'h404, 1'b0);
    hits(0);
    CORE.exec_at(32'h408);
    hits(1);
    wr(8'h20, 32'h400);
    CORE.exec_at(32'h404);
    hits(0);
    CORE.exec_at(32'h800);
    hits(1);
    ce <= 1'b0;
    CORE.exec_at(32'h404);
    CORE.exec_at(32'h800);
    ce <= 1'b1;
    hits(0);
    wr(8'h20, 32'h0);
    $display("test fetch done");
    for (int i = 0; i < 3; i++) begin
      chan(8'h00, 32'h404, 32'h0, off_cond[i]);
      CORE.exec_at(32'h404);
      hits(0);
    end
    chan(8'h00, 32'h405, 32'h0, 32'h15);
    CORE.exec_at(32'h405);
    hits(0);
    chan(8'h00, 32'h400, 32'hff, 32'h15);
    CORE.exec_at(32'h4f0);
    hits(1);
    CORE.exec_at(32'h500);
    hits(0);
    wr(8'h08, 32'h0);
    $display("test conditions done");
    wr(8'h0c, 32'h1003);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(8'h14, d_vb[i]);
      wr(8'h1c, 32'h19 | (32'(d_sz[i]) << 6));
      CORE.data_at(d_ad[i], ubm_size_type'(d_sz[i]), d_fr[i], d_dt[i]);
      CORE.exec_at(32'h2000);
      hits(d_ex[i]);
    end
    wr(8'h1c, 32'h2a);
    CORE.data_at(32'h1003, SZ_BYTE, 1'b1, 32'h0, 1'b1, 1'b1);
    CORE.exec_at(32'h2000);
    hits(1);
    CORE.data_at(32'h1003, SZ_BYTE, 1'b1, 32'h0, 1'b0, 1'b1);
    CORE.exec_at(32'h2000);
    hits(0);
    $display("test data done");
    wr(8'h24, 32'h3);
    wr(8'h20, 32'h1);
    chan(8'h0c, 32'h1000, 32'h0, 32'hd5);
    for (int i = 0; i < 3; i++) begin
      CORE.exec_at(32'h1000);
      hits(32'(i == 2));
    end
    rd(8'h24, 32'h1, '1);
    $display("test count done");
    wr(8'h20, 32'h8);
    chan(8'h00, 32'h500, 32'h0, 32'h15);
    chan(8'h0c, 32'h600, 32'h0, 32'h15);
    CORE.exec_at(32'h600);
    hits(0);
    CORE.exec_at(32'h500);
    hits(0);
    CORE.exec_at(32'h600);
    hits(1);
    CORE.exec_at(32'h500);
    wr(8'h20, 32'h0);
    wr(8'h20, 32'h8);
    CORE.exec_at(32'h600);
    hits(0);
    $display("test chain done");
    wr(8'h08, 32'h0);
    wr(8'h1c, 32'h0);
    wr(8'h20, 32'h100);
    for (int i = 0; i < 5; i++) CORE.branch(32'h7000_0100 + i * 16, 32'hf000_0010 + i * 16);
    for (int k = 4; k > 0; k--) begin
      rd(8'h28, 32'h8000_0000 | ((32'h7000_0100 + k * 16) & 32'h0fff_ffff), '1);
      rd(8'h2c, 32'h8000_0000 | ((32'hf000_0010 + k * 16) & 32'h0fff_ffff), '1);
    end
    rd(8'h2c, 32'h0, 32'h8000_0000);
    wr(8'h20, 32'h0);
    CORE.branch(32'h100, 32'h200);
    rd(8'h2c, 32'h0, 32'h8000_0000);
    wr(8'h20, 32'h100);
    CORE.branch(32'h100, 32'h200);
    wr(8'h20, 32'h100);
    rd(8'h2c, 32'h0, 32'h8000_0000);
    CORE.branch(32'h100, 32'h200);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h2c, 32'h0, 32'h8000_0000);
    rd(8'h20, 32'h0, '1);
    $display("test trace done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
